// [logic/digital_phase_loop_div_pkg.sv]
// Register map, field positions and reset values shared by the divider block
package digital_phase_loop_div_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] REF_LO_IDX = 10'h101;
    localparam logic [IDX_W-1:0] REF_HI_IDX = 10'h102;
    localparam logic [IDX_W-1:0] REF_CTL_IDX = 10'h103;
    localparam logic [IDX_W-1:0] FB_LO_IDX = 10'h104;
    localparam logic [IDX_W-1:0] FB_HI_IDX = 10'h105;
    localparam logic [IDX_W-1:0] FB_CTL_IDX = 10'h106;
    localparam logic [IDX_W-1:0] SEL_IDX = 10'h140;
    localparam logic [IDX_W-1:0] STAT_IDX = 10'h141;
    // Control register fields
    localparam int INV_BIT = 7;
    localparam int PRESC_BIT = 0;
    localparam logic [7:0] CTL_MASK = 8'h81;
    localparam int SEL_BIT = 0;
    // Reset values
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic SEL_RST = 1'b0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/edge_divider.sv]
// Programmable edge divider with optional divide-by-two prescaler
`timescale 1ns/10ps
`default_nettype none
module edge_divider #(
    parameter int W = 16
) (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic edge_en, // One pulse per input edge
    input wire logic [W-1:0] ratio_m1, // Programmed value, ratio minus one
    input wire logic prescale, // Extra divide by two
    output logic tick // One pulse per divided period
);
    typedef struct packed {
        logic [W-1:0] count;
        logic pre;
        logic tick;
    } div_state_t;

    div_state_t st_r;
    div_state_t st_nxt;

    // Prescaler swallows every other edge, counter wraps at programmed value
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (edge_en)
        begin
            if (prescale && !st_r.pre)
            begin
                st_nxt.pre = 1'b1;
            end
            else
            begin
                st_nxt.pre = 1'b0;
                if (st_r.count >= ratio_m1)
                begin
                    st_nxt.count = '0;
                    st_nxt.tick = 1'b1;
                end
                else
                begin
                    st_nxt.count = st_r.count + 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

    sequence s_pass_edge;
        edge_en && ratio_m1 == '0 && !prescale;
    endsequence

    sequence s_skip_edge;
        edge_en && prescale && !st_r.pre;
    endsequence

    AST_TICK_NEEDS_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
        tick |-> $past(edge_en)) else $error("Divider tick without input edge");
    AST_ZERO_PASSES: assert property (@(posedge sys_clk) disable iff (reset)
        s_pass_edge |=> tick) else $error("Ratio one did not pass edge");
    AST_PRESCALE_SKIPS: assert property (@(posedge sys_clk) disable iff (reset)
        s_skip_edge |=> !tick) else $error("Prescaler did not swallow edge");
    AST_MIDCOUNT_QUIET: assert property (@(posedge sys_clk) disable iff (reset)
        (edge_en && !prescale && st_r.count < ratio_m1) |=> !tick) else $error("Tick before count end");
endmodule
`default_nettype wire

// [logic/digital_phase_loop_ref_feedback_dividers.sv]
// Reference and feedback dividers of the digital phase loop with AXI4-Lite registers
//
// What this block does
// - Reference divider divides by programmed value plus one, ratio 1 to 65,536.
// - Reference value low byte at 0x0101, high byte at 0x0102.
// - Both reference bytes zero gives a pass-through ratio of one.
// - Reference control bit 7 inverts the reference clock before the divider.
// - Reference control bit 0 inserts a divide-by-two prescaler.
// - Feedback divider divides by programmed value plus one, ratio 1 to 65,536.
// - Feedback value low byte at 0x0104, high byte at 0x0105.
// - Both feedback bytes zero gives a ratio of one.
// - Feedback control bit 7 inverts the clock entering the feedback divider.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module digital_phase_loop_ref_feedback_dividers (
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic ref_input_first, // First reference clock pin
    input wire logic ref_input_second, // Second reference clock pin
    input wire logic feedback_clock_in, // Feedback clock pin
    output logic ref_div_pulse, // Divided reference pulse
    output logic fb_div_pulse, // Divided feedback pulse
    input wire logic [digital_phase_loop_div_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [digital_phase_loop_div_pkg::DATA_W-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [digital_phase_loop_div_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [digital_phase_loop_div_pkg::DATA_W-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read response valid
    input wire logic s_axi_rready // Read response ready
);
    typedef struct packed {
        logic [7:0] ref_lo;
        logic [7:0] ref_hi;
        logic [7:0] ref_ctl;
        logic [7:0] fb_lo;
        logic [7:0] fb_hi;
        logic [7:0] fb_ctl;
        logic ref_sel;
        logic [1:0] ref_input_first_s;
        logic [1:0] ref_input_second_s;
        logic [1:0] fb_s;
        logic ref_prev;
        logic fb_prev;
        logic [15:0] ref_cnt;
        logic [15:0] fb_cnt;
        logic aw_have;
        logic [digital_phase_loop_div_pkg::ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [digital_phase_loop_div_pkg::DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [digital_phase_loop_div_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    logic ref_raw;
    logic ref_lvl;
    logic ref_edge;
    logic fb_raw;
    logic fb_lvl;
    logic fb_edge;
    logic wr_fire;
    logic [digital_phase_loop_div_pkg::IDX_W-1:0] wr_idx;
    logic ref_tick;
    logic fb_tick;

    // Word index of a byte address
    function automatic logic [digital_phase_loop_div_pkg::IDX_W-1:0] reg_index(input logic [digital_phase_loop_div_pkg::ADDR_W-1:0] a);
        reg_index = a[digital_phase_loop_div_pkg::ADDR_W-1:2];
    endfunction

    // True when an index names a register
    function automatic logic is_mapped(input logic [digital_phase_loop_div_pkg::IDX_W-1:0] i);
        is_mapped = (i == digital_phase_loop_div_pkg::REF_LO_IDX) || (i == digital_phase_loop_div_pkg::REF_HI_IDX) ||
            (i == digital_phase_loop_div_pkg::REF_CTL_IDX) || (i == digital_phase_loop_div_pkg::FB_LO_IDX) ||
            (i == digital_phase_loop_div_pkg::FB_HI_IDX) || (i == digital_phase_loop_div_pkg::FB_CTL_IDX) ||
            (i == digital_phase_loop_div_pkg::SEL_IDX) || (i == digital_phase_loop_div_pkg::STAT_IDX);
    endfunction

    // Read data for an index, reserved bits read zero
    function automatic logic [digital_phase_loop_div_pkg::DATA_W-1:0] read_word(input top_state_t s,
        input logic [digital_phase_loop_div_pkg::IDX_W-1:0] i);
        read_word = '0;
        case (i)
            digital_phase_loop_div_pkg::REF_LO_IDX: read_word[7:0] = s.ref_lo;
            digital_phase_loop_div_pkg::REF_HI_IDX: read_word[7:0] = s.ref_hi;
            digital_phase_loop_div_pkg::REF_CTL_IDX: read_word[7:0] = s.ref_ctl & digital_phase_loop_div_pkg::CTL_MASK;
            digital_phase_loop_div_pkg::FB_LO_IDX: read_word[7:0] = s.fb_lo;
            digital_phase_loop_div_pkg::FB_HI_IDX: read_word[7:0] = s.fb_hi;
            digital_phase_loop_div_pkg::FB_CTL_IDX: read_word[7:0] = s.fb_ctl & digital_phase_loop_div_pkg::CTL_MASK;
            digital_phase_loop_div_pkg::SEL_IDX: read_word[digital_phase_loop_div_pkg::SEL_BIT] = s.ref_sel;
            digital_phase_loop_div_pkg::STAT_IDX: read_word = {s.fb_cnt, s.ref_cnt};
            default: read_word = '0;
        endcase
    endfunction

    // Pick the reference pin, then optionally invert so falling edges count
    assign ref_raw = st_r.ref_sel ? st_r.ref_input_second_s[1] : st_r.ref_input_first_s[1];
    assign ref_lvl = ref_raw ^ st_r.ref_ctl[digital_phase_loop_div_pkg::INV_BIT];
    assign ref_edge = ref_lvl & ~st_r.ref_prev;
    assign fb_raw = st_r.fb_s[1];
    assign fb_lvl = fb_raw ^ st_r.fb_ctl[digital_phase_loop_div_pkg::INV_BIT];
    assign fb_edge = fb_lvl & ~st_r.fb_prev;

    // A write completes once both address and data are held and no write response is pending
    assign wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    assign wr_idx = reg_index(st_r.aw_addr);

    // Next state: synchronisers, edge history, tick counters and bus slave
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ref_input_first_s = {st_r.ref_input_first_s[0], ref_input_first};
        st_nxt.ref_input_second_s = {st_r.ref_input_second_s[0], ref_input_second};
        st_nxt.fb_s = {st_r.fb_s[0], feedback_clock_in};
        st_nxt.ref_prev = ref_lvl;
        st_nxt.fb_prev = fb_lvl;
        if (ref_tick)
            st_nxt.ref_cnt = st_r.ref_cnt + 1'b1;
        if (fb_tick)
            st_nxt.fb_cnt = st_r.fb_cnt + 1'b1;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = is_mapped(wr_idx) ? digital_phase_loop_div_pkg::RESP_OKAY : digital_phase_loop_div_pkg::RESP_SLVERR;
            if (st_r.w_strb[0])
            begin
                case (wr_idx)
                    digital_phase_loop_div_pkg::REF_LO_IDX: st_nxt.ref_lo = st_r.w_data[7:0];
                    digital_phase_loop_div_pkg::REF_HI_IDX: st_nxt.ref_hi = st_r.w_data[7:0];
                    digital_phase_loop_div_pkg::REF_CTL_IDX: st_nxt.ref_ctl = st_r.w_data[7:0] & digital_phase_loop_div_pkg::CTL_MASK;
                    digital_phase_loop_div_pkg::FB_LO_IDX: st_nxt.fb_lo = st_r.w_data[7:0];
                    digital_phase_loop_div_pkg::FB_HI_IDX: st_nxt.fb_hi = st_r.w_data[7:0];
                    digital_phase_loop_div_pkg::FB_CTL_IDX: st_nxt.fb_ctl = st_r.w_data[7:0] & digital_phase_loop_div_pkg::CTL_MASK;
                    digital_phase_loop_div_pkg::SEL_IDX: st_nxt.ref_sel = st_r.w_data[digital_phase_loop_div_pkg::SEL_BIT];
                    default: st_nxt.ref_sel = st_r.ref_sel;
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = read_word(st_r, reg_index(s_axi_araddr));
            st_nxt.rresp = is_mapped(reg_index(s_axi_araddr)) ? digital_phase_loop_div_pkg::RESP_OKAY :
                digital_phase_loop_div_pkg::RESP_SLVERR;
        end
        else if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // State register with defined reset values
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.ref_lo <= digital_phase_loop_div_pkg::DIV_RST;
            st_r.ref_hi <= digital_phase_loop_div_pkg::DIV_RST;
            st_r.ref_ctl <= digital_phase_loop_div_pkg::CTL_RST;
            st_r.fb_lo <= digital_phase_loop_div_pkg::DIV_RST;
            st_r.fb_hi <= digital_phase_loop_div_pkg::DIV_RST;
            st_r.fb_ctl <= digital_phase_loop_div_pkg::CTL_RST;
            st_r.ref_sel <= digital_phase_loop_div_pkg::SEL_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Reference divider, fed by the selected and optionally inverted pin
    edge_divider #(
        .W(16)
    ) u_ref_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .edge_en(ref_edge),
        .ratio_m1({st_r.ref_hi, st_r.ref_lo}),
        .prescale(st_r.ref_ctl[digital_phase_loop_div_pkg::PRESC_BIT]),
        .tick(ref_tick)
    );

    // Feedback divider, fed by the feedback pin
    edge_divider #(
        .W(16)
    ) u_fb_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .edge_en(fb_edge),
        .ratio_m1({st_r.fb_hi, st_r.fb_lo}),
        .prescale(st_r.fb_ctl[digital_phase_loop_div_pkg::PRESC_BIT]),
        .tick(fb_tick)
    );

    // Outputs; handshake readies are combinational
    assign ref_div_pulse = ref_tick;
    assign fb_div_pulse = fb_tick;
    assign s_axi_awready = !st_r.aw_have;
    assign s_axi_wready = !st_r.w_have;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    sequence s_ref_lo_write;
        wr_fire && wr_idx == digital_phase_loop_div_pkg::REF_LO_IDX && st_r.w_strb[0];
    endsequence

    sequence s_fb_hi_write;
        wr_fire && wr_idx == digital_phase_loop_div_pkg::FB_HI_IDX && st_r.w_strb[0];
    endsequence

    sequence s_ref_inv_fall;
        st_r.ref_ctl[digital_phase_loop_div_pkg::INV_BIT] && $stable(st_r.ref_ctl) && $stable(st_r.ref_sel) && $fell(ref_raw);
    endsequence

    sequence s_fb_inv_fall;
        st_r.fb_ctl[digital_phase_loop_div_pkg::INV_BIT] && $stable(st_r.fb_ctl) && $fell(fb_raw);
    endsequence

    AST_REF_LO_STORED: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_lo_write |=> st_r.ref_lo == $past(st_r.w_data[7:0])) else $error("Reference low byte not stored");
    AST_FB_HI_STORED: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_hi_write |=> st_r.fb_hi == $past(st_r.w_data[7:0])) else $error("Feedback high byte not stored");
    AST_REF_INVERT: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_inv_fall |-> ref_edge) else $error("Inverted reference falling edge missed");
    AST_FB_INVERT: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_inv_fall |-> fb_edge) else $error("Inverted feedback falling edge missed");
    AST_RESP_AFTER_BOTH: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(st_r.bvalid) |-> $past(st_r.aw_have && st_r.w_have)) else $error("Write answered early");
    AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && !is_mapped(reg_index(s_axi_araddr)))
        |=> s_axi_rvalid && s_axi_rresp == digital_phase_loop_div_pkg::RESP_SLVERR && s_axi_rdata == '0)
        else $error("Unmapped read not refused");

    // Remaining value bytes land in the divider settings
    sequence s_ref_hi_write;
        wr_fire && wr_idx == digital_phase_loop_div_pkg::REF_HI_IDX && st_r.w_strb[0];
    endsequence

    sequence s_fb_lo_write;
        wr_fire && wr_idx == digital_phase_loop_div_pkg::FB_LO_IDX && st_r.w_strb[0];
    endsequence

    AST_REF_HI_STORED: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_hi_write |=> st_r.ref_hi == $past(st_r.w_data[7:0])) else $error("Reference high byte not stored");
    AST_FB_LO_STORED: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_lo_write |=> st_r.fb_lo == $past(st_r.w_data[7:0])) else $error("Feedback low byte not stored");

    // Without inversion a rising pin level is the counted edge
    sequence s_ref_plain_rise;
        !st_r.ref_ctl[digital_phase_loop_div_pkg::INV_BIT] && $stable(st_r.ref_ctl) && $stable(st_r.ref_sel) && $rose(ref_raw);
    endsequence

    sequence s_fb_plain_rise;
        !st_r.fb_ctl[digital_phase_loop_div_pkg::INV_BIT] && $stable(st_r.fb_ctl) && $rose(fb_raw);
    endsequence

    AST_REF_PLAIN_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_plain_rise |-> ref_edge) else $error("Reference rising edge missed");
    AST_FB_PLAIN_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_plain_rise |-> fb_edge) else $error("Feedback rising edge missed");

    // No edge event while the pin level and its controls hold still
    sequence s_ref_quiet;
        $stable(ref_raw) && $stable(st_r.ref_ctl) && $stable(st_r.ref_sel);
    endsequence

    sequence s_fb_quiet;
        $stable(fb_raw) && $stable(st_r.fb_ctl);
    endsequence

    AST_REF_NO_FALSE_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_quiet |-> !ref_edge) else $error("Reference edge without pin change");
    AST_FB_NO_FALSE_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_quiet |-> !fb_edge) else $error("Feedback edge without pin change");

    // A zero value with no prescaler passes every edge to the output
    sequence s_ref_ratio_one;
        ref_edge && {st_r.ref_hi, st_r.ref_lo} == 16'h0000 && !st_r.ref_ctl[digital_phase_loop_div_pkg::PRESC_BIT];
    endsequence

    sequence s_fb_ratio_one;
        fb_edge && {st_r.fb_hi, st_r.fb_lo} == 16'h0000 && !st_r.fb_ctl[digital_phase_loop_div_pkg::PRESC_BIT];
    endsequence

    AST_REF_RATIO_ONE: assert property (@(posedge sys_clk) disable iff (reset)
        s_ref_ratio_one |=> ref_div_pulse) else $error("Reference ratio one lost an edge");
    AST_FB_RATIO_ONE: assert property (@(posedge sys_clk) disable iff (reset)
        s_fb_ratio_one |=> fb_div_pulse) else $error("Feedback ratio one lost an edge");

    // Status counters follow the divided pulses
    AST_REF_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (reset)
        ref_tick |=> st_r.ref_cnt == $past(st_r.ref_cnt) + 16'h0001) else $error("Reference count missed a pulse");
    AST_FB_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (reset)
        fb_tick |=> st_r.fb_cnt == $past(st_r.fb_cnt) + 16'h0001) else $error("Feedback count missed a pulse");

    // Bus answers: unmapped writes refused, every taken read answered next cycle
    AST_UNMAPPED_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        (wr_fire && !is_mapped(wr_idx)) |=> s_axi_bvalid && s_axi_bresp == digital_phase_loop_div_pkg::RESP_SLVERR)
        else $error("Unmapped write not refused");
    AST_READ_ANSWERED: assert property (@(posedge sys_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("Read not answered");
endmodule
`default_nettype wire

// [dv/clk_source_model.sv]
// Behavioural external clock source driving one clock pin of the divider block
`timescale 1ns/10ps
`default_nettype none
module clk_source_model #(
    parameter int HALF = 8
) (
    input wire logic sys_clk, // System clock
    input wire logic run, // Keep producing periods while high
    output logic pin // Clock pin toward the block
);
    logic pin_r = 1'b0;
    int cnt_r = 0;
    assign pin = pin_r;
    // Slow clock, one period every 16 system cycles, parks low once a started period ends
    always @(posedge sys_clk)
    begin
        if (run || pin_r)
        begin
            if (cnt_r == HALF - 1)
            begin
                cnt_r <= 0;
                pin_r <= !pin_r;
            end
            else
                cnt_r <= cnt_r + 1;
        end
        else
            cnt_r <= 0;
    end
endmodule
`default_nettype wire

// [dv/test_digital_phase_loop_ref_feedback_dividers.sv]
// Self-checking testbench for the reference and feedback dividers
`timescale 1ns/10ps
`default_nettype none
module test_digital_phase_loop_ref_feedback_dividers;
    logic sys_clk = 1'b0, reset = 1'b1, sel = 1'b0;
    logic run_a = 1'b0, run_b = 1'b0, run_f = 1'b0;
    logic pin_a, pin_b, pin_f, ref_div_pulse, fb_div_pulse;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [9:0] idx;
    int num_errors = 0, checked = 0, ref_n = 0, ref_hi = 0, fb_n = 0, fb_hi = 0;
    // Clock sources for both reference pins and the feedback pin
    clk_source_model #(.HALF(8)) src_a (.sys_clk(sys_clk), .run(run_a), .pin(pin_a));
    clk_source_model #(.HALF(8)) src_b (.sys_clk(sys_clk), .run(run_b), .pin(pin_b));
    clk_source_model #(.HALF(8)) src_f (.sys_clk(sys_clk), .run(run_f), .pin(pin_f));
    digital_phase_loop_ref_feedback_dividers DUT (.sys_clk(sys_clk), .reset(reset), .ref_input_first(pin_a),
        .ref_input_second(pin_b), .feedback_clock_in(pin_f), .ref_div_pulse(ref_div_pulse),
        .fb_div_pulse(fb_div_pulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;
    // Count divided pulses mid-cycle, and those landing while the source pin is high
    always @(negedge sys_clk)
    begin
        if (ref_div_pulse === 1'b1)
        begin
            ref_n++;
            if ((sel ? pin_b : pin_a) === 1'b1)
                ref_hi++;
        end
        if (fb_div_pulse === 1'b1)
        begin
            fb_n++;
            if (pin_f === 1'b1)
                fb_hi++;
        end
    end
    // Compare and tally
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task end_sim;
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset held for 8 cycles, then settle
    task automatic do_reset;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // AXI4-Lite write; ready is read mid-cycle, so it is what the next rising edge samples
    task automatic axw(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rs;
        int n;
        n = 0;
        tb = 1'b0;
        @(posedge sys_clk);
        awaddr <= {i, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (tb !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        chk(tb, 1'b1);
        chk(rs, er);
    endtask
    // AXI4-Lite read with expected data and response
    task automatic axr(input logic [9:0] i, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [1:0] rs;
        logic [31:0] rd;
        int n;
        n = 0;
        tr = 1'b0;
        @(posedge sys_clk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (tr !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            ta = arvalid && arready;
            tr = rvalid;
            rs = rresp;
            rd = rdata;
            @(posedge sys_clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        chk(tr, 1'b1);
        chk(rs, er);
        chk(rd, ed);
    endtask
    // Program both dividers alike, send e source edges, expect k pulses, khi of them while the pin is high
    task automatic run_case(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ctl, input logic s,
        input int e, input int k, input int khi);
        int n;
        do_reset;
        axw(digital_phase_loop_div_pkg::REF_LO_IDX, {24'h0, lo}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::REF_HI_IDX, {24'h0, hi}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::REF_CTL_IDX, {24'h0, ctl}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::FB_LO_IDX, {24'h0, lo}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::FB_HI_IDX, {24'h0, hi}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::FB_CTL_IDX, {24'h0, ctl}, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::SEL_IDX, {31'h0, s}, digital_phase_loop_div_pkg::RESP_OKAY);
        sel = s;
        repeat (8) @(posedge sys_clk);
        ref_n = 0;
        ref_hi = 0;
        fb_n = 0;
        fb_hi = 0;
        n = 0;
        run_a <= !s;
        run_b <= s;
        run_f <= 1'b1;
        while (n < e)
        begin
            @(posedge pin_f);
            n++;
        end
        run_a <= 1'b0;
        run_b <= 1'b0;
        run_f <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk(ref_n, k);
        chk(ref_hi, khi);
        chk(fb_n, k);
        chk(fb_hi, khi);
        if (!ctl[7])
            axr(digital_phase_loop_div_pkg::STAT_IDX, {16'(k), 16'(k)}, digital_phase_loop_div_pkg::RESP_OKAY);
    endtask
    // Main sequence
    initial
    begin
        do_reset;
        // Reset values, stored bits of each register, unmapped and read-only places
        for (int i = 0; i < 6; i++)
        begin
            idx = digital_phase_loop_div_pkg::REF_LO_IDX + 10'(i);
            axr(idx, 32'h0000_0000, digital_phase_loop_div_pkg::RESP_OKAY);
            axw(idx, 32'h1234_56ff, digital_phase_loop_div_pkg::RESP_OKAY);
            axr(idx, (i == 2 || i == 5) ? 32'h0000_0081 : 32'h0000_00ff, digital_phase_loop_div_pkg::RESP_OKAY);
        end
        axw(10'h107, 32'h0000_00ff, digital_phase_loop_div_pkg::RESP_SLVERR);
        axr(10'h107, 32'h0000_0000, digital_phase_loop_div_pkg::RESP_SLVERR);
        axw(digital_phase_loop_div_pkg::STAT_IDX, 32'hffff_ffff, digital_phase_loop_div_pkg::RESP_OKAY);
        axr(digital_phase_loop_div_pkg::STAT_IDX, 32'h0000_0000, digital_phase_loop_div_pkg::RESP_OKAY);
        axr(digital_phase_loop_div_pkg::SEL_IDX, 32'h0000_0000, digital_phase_loop_div_pkg::RESP_OKAY);
        axw(digital_phase_loop_div_pkg::SEL_IDX, 32'hffff_ffff, digital_phase_loop_div_pkg::RESP_OKAY);
        axr(digital_phase_loop_div_pkg::SEL_IDX, 32'h0000_0001, digital_phase_loop_div_pkg::RESP_OKAY);
        run_case(8'h00, 8'h00, 8'h00, 1'b0, 5, 5, 5);
        run_case(8'h02, 8'h00, 8'h00, 1'b0, 9, 3, 3);
        run_case(8'h00, 8'h01, 8'h00, 1'b0, 514, 2, 2);
        run_case(8'h01, 8'h00, 8'h01, 1'b0, 8, 2, 2);
        run_case(8'h00, 8'h00, 8'h01, 1'b1, 6, 3, 3);
        run_case(8'h00, 8'h00, 8'h80, 1'b0, 5, 5, 0);
        end_sim;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #5_000_000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
